// >>> bit_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are levels from another clock domain
// Notes: only the second stage may be read by logic
`timescale 1ns/10ps
module bit_sync #(parameter int W = 1) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // level in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta; // first stage, read by q only

    // two flops back to back
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// >>> crc7_step.sv
// Purpose: one serial step of the 7-bit command checksum
// Assumes: generator x^7 + x^3 + 1, msb first
// Notes: purely combinational
`timescale 1ns/10ps
module crc7_step (
    // running value and next bit
    input wire logic [6:0] crc,
    input wire logic bit_in,
    // updated value
    output logic [6:0] crc_next
);
    logic fb; // feedback term

    // shift left, fold feedback into taps 3 and 0
    always_comb begin
        fb = crc[6] ^ bit_in;
        crc_next = {crc[5:3], crc[2] ^ fb, crc[1:0], fb};
    end
endmodule

// >>> memcard_cmd_asserts.sv
// Purpose: port checker for the card command core
// Assumes: card clock period is 8 core cycles
// Notes: bound from the bench top file
`timescale 1ns/10ps
module memcard_cmd_asserts
    import memcard_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // card bus
    input wire logic cmd_out,
    input wire logic cmd_oe,
    input wire logic dat_out,
    input wire logic dat_oe,
    // register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // cycles the card has held the command line; a counter
    // because a 48-bit reply is far past any repetition
    logic [9:0] oe_cnt;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) oe_cnt <= 10'h000;
        else if (cmd_oe) oe_cnt <= oe_cnt + 10'h001;
        else oe_cnt <= 10'h000;
    end
    sequence s_rd_take;
        arvalid && arready;
    endsequence
    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    a_reply_start: assert property ($rose(cmd_oe) |-> !cmd_out)
        else $error("reply start bit not low");
    a_reply_end: assert property ($fell(cmd_oe) |-> $past(cmd_out))
        else $error("reply end bit not high");
    a_reply_len: assert property ($fell(cmd_oe) |->
        oe_cnt >= 10'h17e && oe_cnt <= 10'h182)
        else $error("reply not 48 card clocks");
    a_busy_low: assert property (dat_oe |-> !dat_out)
        else $error("data line driven high");
    a_rd_answer: assert property (s_rd_take |=> rvalid)
        else $error("read not answered");
    a_ar_block: assert property (rvalid |-> !arready)
        else $error("read taken while answering");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    a_wr_answer: assert property (s_wr_take |-> ##[1:2] bvalid)
        else $error("write not answered");
    a_b_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped early");
endmodule

// >>> memcard_cmd_core.sv
// Purpose: command layer of a removable flash card
// Assumes: card_clk is slow against core_clk (8x or more)
// Notes: memory array itself sits outside; timing is modelled
//
// Contract
// - card only answers commands, never starts
// - byte is smallest unit; blocks whole bytes
// - sector size equals write block length
// - one tag bit per sector, group
// - erase clears all tagged units at once
// - non-tag commands clear every tag bit
// - other commands abandon pending tag-erase
// - write-protect bit per protect group
// - command classes 0 to 7 supported
// - class 0 always; classes reported
// - bc silent, others answer on cmd
// - frame 48 bits, msb first, crc, end
// - index 6 bits, argument 32, crc 7
// - abort with error past ten times typical
// - read latency is async plus clock access
// - program time is read latency times factor
// - write speed factor code 2 means 4
// - erase group spans 16 write blocks
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "memcard_consts.svh"
module memcard_cmd_core
    import memcard_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // card bus pins
    input wire logic card_clk,
    input wire logic cmd_in,
    output logic cmd_out,
    output logic cmd_oe,
    output logic dat_out,
    output logic dat_oe,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [4:0] awaddr,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [4:0] araddr,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    ////////////////////////////////////////////////////////////////////
    core_s s; // registered state
    core_s n; // next state
    logic [1:0] pins_s; // synchronised {card_clk, cmd_in}
    logic lclk; // link clock level
    logic cmd_bit; // command line level
    logic [6:0] rx_crc_nx; // receive checksum step
    logic [6:0] tx_crc_nx; // transmit checksum step
    logic [6:0] rx_crc_in; // receive checksum seed
    logic tx_bit; // bit going out on this edge

    // both pins are sampled together so their skew is kept
    bit_sync #(.W(2)) u_sync (
        .clk(core_clk),
        .rst(sys_rst),
        .d({card_clk, cmd_in}),
        .q(pins_s)
    );
    assign lclk = pins_s[1];
    assign cmd_bit = pins_s[0];
    assign rx_crc_in = (s.rx == RX_IDLE) ? 7'h00 : s.rx_crc;
    crc7_step u_rx_crc (
        .crc(rx_crc_in),
        .bit_in(cmd_bit),
        .crc_next(rx_crc_nx)
    );
    // checksum bits replace the shifter for bits 40 to 46
    assign tx_bit = (s.tx_cnt >= `CRC_END && s.tx_cnt < `FRAME_LAST) ?
        s.tx_crc[6] : s.tx_sh[47];
    crc7_step u_tx_crc (
        .crc(s.tx_crc),
        .bit_in(tx_bit),
        .crc_next(tx_crc_nx)
    );

    ////////////////////////////////////////////////////////////////////
    // next-state logic: link edges, frame receive, commands, timer, bus
    always_comb begin
        logic rise;
        logic fall;
        logic [47:0] fr;
        logic fr_done;
        logic fr_ok;
        logic [5:0] idx;
        logic [31:0] arg;
        logic sup;
        logic silent;
        logic is_tag;
        logic [5:0] sect;
        logic [1:0] grp;
        logic [31:0] rd_typ;
        logic [31:0] typ;
        logic [31:0] st;
        logic [31:0] rv;
        rise = 1'b0;
        fall = 1'b0;
        fr = '0;
        fr_done = 1'b0;
        fr_ok = 1'b0;
        idx = '0;
        arg = '0;
        sup = 1'b0;
        silent = 1'b0;
        is_tag = 1'b0;
        sect = '0;
        grp = '0;
        rd_typ = '0;
        typ = '0;
        st = '0;
        rv = '0;
        n = s;
        // link clock edges found on the synchronised level
        rise = lclk & ~s.lclk_d;
        fall = ~lclk & s.lclk_d;
        n.lclk_d = lclk;

        // register bus: address and data taken in either order
        if (awvalid && s.awready) begin
            n.aw_have = 1'b1;
            n.waddr = awaddr;
        end
        if (wvalid && s.wready) begin
            n.w_have = 1'b1;
            n.wdata = wdata;
            n.wstrb = wstrb;
        end
        if (bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        // both halves held: perform the write and answer
        if (s.aw_have && s.w_have && !s.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `RESP_OKAY;
            case (s.waddr)
                `REG_ASYNC: begin
                    if (s.wstrb[0]) n.async_cyc[7:0] = s.wdata[7:0];
                    if (s.wstrb[1]) n.async_cyc[15:8] = s.wdata[15:8];
                end
                `REG_CLKACC: begin
                    if (s.wstrb[0]) n.clkacc_cyc[7:0] = s.wdata[7:0];
                    if (s.wstrb[1]) n.clkacc_cyc[15:8] = s.wdata[15:8];
                end
                `REG_CTRL: begin
                    // error clear first; a new error later wins
                    if (s.wstrb[0]) begin
                        n.stall = s.wdata[0];
                        if (s.wdata[1]) n.err = 1'b0;
                    end
                end
                // read-only or unmapped: refused with an error
                default: n.bresp = `RESP_SLVERR;
            endcase
        end
        if (rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        // read: answer the cycle after the address is taken
        if (arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = `RESP_OKAY;
            case (araddr)
                `REG_ASYNC: rv = {16'h0000, s.async_cyc};
                `REG_CLKACC: rv = {16'h0000, s.clkacc_cyc};
                `REG_CTRL: rv = {31'h0000_0000, s.stall};
                `REG_STATUS: begin
                    rv = {8'h00, s.crc_fail, 2'h0, s.last_cmd,
                        3'h0, s.aborted, s.tag_pend, s.err,
                        s.op != OP_NONE, s.op == OP_READ};
                end
                `REG_CARD: begin
                    rv = {5'h00, `WSF_CODE, 4'h0, `BLK_LEN_CODE, 4'h0,
                        `CLASS_FIELD};
                end
                `REG_TAGS: rv = {20'h0_0000, s.wp, 4'h0, s.grp_tag};
                default: begin
                    rv = '0;
                    n.rresp = `RESP_SLVERR;
                end
            endcase
            n.rdata = rv;
        end
        n.awready = ~n.aw_have & ~n.bvalid;
        n.wready = ~n.w_have & ~n.bvalid;
        n.arready = ~n.rvalid;

        if (rise) begin
            case (s.rx)
                RX_IDLE: begin
                    if (!cmd_bit && s.tx == TX_IDLE) begin
                        n.rx = RX_SHIFT;
                        n.rx_cnt = 6'h01;
                        n.rx_sh = {47'h0, cmd_bit};
                        n.rx_crc = rx_crc_nx;
                    end
                end
                RX_SHIFT: begin
                    n.rx_sh = {s.rx_sh[46:0], cmd_bit};
                    if (s.rx_cnt < `CRC_END) n.rx_crc = rx_crc_nx;
                    n.rx_cnt = s.rx_cnt + 6'h01;
                    if (s.rx_cnt == `FRAME_LAST) begin
                        n.rx = RX_IDLE;
                        fr = {s.rx_sh[46:0], cmd_bit};
                        fr_done = 1'b1;
                    end
                end
                default: n.rx = RX_IDLE;
            endcase
        end
        idx = fr[45:40];
        arg = fr[39:8];
        fr_ok = fr_done && fr[46] && fr[0] && (fr[7:1] == s.rx_crc);
        if (fr_done && !fr_ok) n.crc_fail = s.crc_fail + 8'h01;

        // class 0 to 7 command set
        case (idx)
            6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h07, 6'h09, 6'h0a,
            6'h0b, 6'h0c, 6'h0d, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h14,
            6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e,
            6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26,
            6'h2a: sup = 1'b1;
            default: sup = 1'b0;
        endcase
        silent = (idx == 6'h00) || (idx == 6'h04) || (idx == 6'h0f);
        is_tag = (idx >= `CMD_TAG_S0) && (idx <= `CMD_UNTAG_G);
        sect = arg[`SECT_MSB:`SECT_LSB];
        grp = arg[`SECT_MSB:`GRP_LSB];

        if (fr_ok && sup) begin
            n.last_cmd = idx;
            if (!is_tag && idx != `CMD_ERASE) begin
                n.aborted = s.tag_pend;
                n.tag_pend = 1'b0;
            end
            if (!is_tag) begin
                n.sect_tag = '0;
                n.grp_tag = '0;
            end
            case (idx)
                `CMD_TAG_S0, `CMD_TAG_S1: begin
                    n.sect_tag[sect] = 1'b1;
                    n.tag_pend = 1'b1;
                    n.aborted = 1'b0;
                end
                `CMD_UNTAG_S: n.sect_tag[sect] = 1'b0;
                `CMD_TAG_G0, `CMD_TAG_G1: begin
                    n.grp_tag[grp] = 1'b1;
                    n.tag_pend = 1'b1;
                    n.aborted = 1'b0;
                end
                `CMD_UNTAG_G: n.grp_tag[grp] = 1'b0;
                // all tagged units in one erase
                `CMD_ERASE: begin
                    if (s.tag_pend && s.op == OP_NONE) begin
                        n.op = OP_PROG;
                        n.op_cnt = '0;
                    end
                    n.tag_pend = 1'b0;
                end
                `CMD_SET_WP, `CMD_CLR_WP: begin
                    if (s.op == OP_NONE) begin
                        n.wp[grp] = (idx == `CMD_SET_WP);
                        n.op = OP_PROG;
                        n.op_cnt = '0;
                    end
                end
                6'h14, 6'h18, 6'h19, 6'h1a, 6'h1b: begin
                    if (s.op == OP_NONE) begin
                        n.op = OP_PROG;
                        n.op_cnt = '0;
                    end
                end
                6'h0b, 6'h11, 6'h12: begin
                    if (s.op == OP_NONE) begin
                        n.op = OP_READ;
                        n.op_cnt = '0;
                    end
                end
                default: begin
                end
            endcase
            if (!silent) begin
                st[`ST_ERR] = s.err;
                st[`ST_ABORT] = n.aborted;
                st[`ST_READY] = (s.op == OP_NONE);
                n.tx = TX_WAIT;
                n.tx_cnt = {4'h0, `RESP_DELAY};
                n.tx_sh = {2'b00, idx, st, 7'h00, 1'b1};
                n.tx_crc = 7'h00;
            end
        end

        // read latency from both access terms
        rd_typ = {16'h0000, s.async_cyc} + {16'h0000, s.clkacc_cyc};
        typ = (s.op == OP_READ) ? rd_typ : rd_typ << `WSF_CODE;
        if (s.op != OP_NONE) begin
            n.op_cnt = s.op_cnt + 32'h0000_0001;
            // give up past ten times typical
            if (s.op_cnt >= 32'(typ * `TIMEOUT_MULT)) begin
                n.op = OP_NONE;
                n.err = 1'b1;
            end else if (s.op_cnt >= typ && !s.stall) begin
                n.op = OP_NONE;
                n.rd_tok = (s.op == OP_READ);
            end
        end

        // response and data line change on falling link edges
        if (fall) begin
            // busy low while programming, start bit held two card clocks for reads
            n.dat_oe = (s.op == OP_PROG) | s.rd_tok;
            n.dat_out = 1'b0;
            if (s.rd_tok && s.dat_oe) n.rd_tok = 1'b0;
            case (s.tx)
                TX_IDLE: n.cmd_oe = 1'b0;
                TX_WAIT: begin
                    n.tx_cnt = s.tx_cnt - 6'h01;
                    if (s.tx_cnt == 6'h01) begin
                        n.tx = TX_SHIFT;
                        n.tx_cnt = '0;
                    end
                end
                TX_SHIFT: begin
                    n.cmd_oe = (s.tx_cnt != `FRAME_BITS);
                    n.cmd_out = tx_bit | (s.tx_cnt == `FRAME_BITS);
                    n.tx_sh = {s.tx_sh[46:0], 1'b0};
                    n.tx_cnt = s.tx_cnt + 6'h01;
                    if (s.tx_cnt < `CRC_END) n.tx_crc = tx_crc_nx;
                    else n.tx_crc = {s.tx_crc[5:0], 1'b0};
                    if (s.tx_cnt == `FRAME_BITS) n.tx = TX_IDLE;
                end
                default: n.tx = TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register; bus ready lines start high
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
            s.cmd_out <= 1'b1;
            s.dat_out <= 1'b1;
            s.async_cyc <= `ASYNC_RST;
            s.clkacc_cyc <= `CLKACC_RST;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign cmd_out = s.cmd_out;
    assign cmd_oe = s.cmd_oe;
    assign dat_out = s.dat_out;
    assign dat_oe = s.dat_oe;
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
endmodule

// >>> memcard_consts.svh
// Purpose: shared constants of the card command layer
// Assumes: one card, one command line and one data line
// Notes: offsets are byte addresses on the register bus
`ifndef MEMCARD_CONSTS_SVH
`define MEMCARD_CONSTS_SVH
// frame layout: 48 bits, crc covers the first 40
`define FRAME_LAST 6'h2f
`define CRC_END 6'h28
`define FRAME_BITS 6'h30
`define RESP_DELAY 2'h2
// card-specific data values
`define WSF_CODE 3'h2
`define BLK_LEN_CODE 4'h9
`define CLASS_FIELD 12'h00ff
`define TIMEOUT_MULT 32'h0000_000a
// address slices: byte address -> sector, group
`define SECT_LSB 9
`define SECT_MSB 14
`define GRP_LSB 13
// response status bits
`define ST_ERR 19
`define ST_ABORT 13
`define ST_READY 8
// command indexes
`define CMD_TAG_S0 6'h20
`define CMD_TAG_S1 6'h21
`define CMD_UNTAG_S 6'h22
`define CMD_TAG_G0 6'h23
`define CMD_TAG_G1 6'h24
`define CMD_UNTAG_G 6'h25
`define CMD_ERASE 6'h26
`define CMD_SET_WP 6'h1c
`define CMD_CLR_WP 6'h1d
// register offsets
`define REG_ASYNC 5'h00
`define REG_CLKACC 5'h04
`define REG_CTRL 5'h08
`define REG_STATUS 5'h0c
`define REG_CARD 5'h10
`define REG_TAGS 5'h14
// register reset values and bus response codes
`define ASYNC_RST 16'h0010
`define CLKACC_RST 16'h0004
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> memcard_host_model.sv
// Purpose: host controller model on the card bus
// Assumes: command line pulled up while released
// Notes: card clock stands still between commands
`timescale 1ns/10ps
module memcard_host_model
    import memcard_pkg::*;
(
    // card bus
    input wire logic cmd_wire,
    output logic card_clk,
    output logic host_oe,
    output logic host_out,
    // captured reply
    output logic resp_stb,
    output logic [47:0] resp_word
);
    initial begin
        card_clk = 1'b0;
        host_oe = 1'b0;
        host_out = 1'b1;
        resp_stb = 1'b0;
        resp_word = 48'h0;
    end
    ////////////////////////////////////////
    // checksum, init zero
    function automatic logic [6:0] crc7(input logic [39:0] f);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            c = {c[5:0], 1'b0} ^ ((f[i] ^ c[6]) ? 7'h09 : 7'h00);
        end
        return c;
    endfunction
    task automatic send(input logic [5:0] idx, input logic [31:0] arg,
                        input logic bad);
        logic [47:0] fr;
        logic [47:0] sh;
        int n;
        #10; // pins move off the core clock edges
        fr[47:8] = {1'b0, 1'b1, idx, arg};
        fr[7:0] = {crc7(fr[47:8]) ^ {6'h00, bad}, 1'b1};
        n = 0;
        sh = 48'h0;
        for (int i = 47; i >= 0; i--) begin
            host_oe = 1'b1;
            host_out = fr[i];
            #160 card_clk = 1'b1;
            #160 card_clk = 1'b0;
        end
        // release; sample just before each fall, where the bit is settled
        host_oe = 1'b0;
        for (int p = 0; p < 60; p++) begin
            #160 card_clk = 1'b1;
            #160;
            if (n > 0 || cmd_wire === 1'b0) begin
                sh = {sh[46:0], cmd_wire};
                n++;
            end
            card_clk = 1'b0;
            if (n == 48) begin
                resp_word = sh;
                resp_stb = 1'b1;
                #1 resp_stb = 1'b0;
            end
        end
    endtask
endmodule

// >>> memcard_pkg.sv
// Purpose: types of the card command layer
// Assumes: constants come from memcard_consts.svh
// Notes: all state of the core is one packed struct
package memcard_pkg;
    typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_SHIFT = 1'b1} rx_e;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_SHIFT = 2'b10
    } tx_e;
    typedef enum logic [1:0] {
        OP_NONE = 2'b00, OP_READ = 2'b01, OP_PROG = 2'b10
    } op_e;
    typedef struct packed {
        rx_e rx;
        logic [5:0] rx_cnt;
        logic [47:0] rx_sh;
        logic [6:0] rx_crc;
        tx_e tx;
        logic [5:0] tx_cnt;
        logic [47:0] tx_sh;
        logic [6:0] tx_crc;
        logic cmd_out;
        logic cmd_oe;
        logic dat_out;
        logic dat_oe;
        logic lclk_d;
        op_e op;
        logic [31:0] op_cnt;
        logic rd_tok;
        logic [63:0] sect_tag;
        logic [3:0] grp_tag;
        logic [3:0] wp;
        logic tag_pend;
        logic aborted;
        logic err;
        logic [15:0] async_cyc;
        logic [15:0] clkacc_cyc;
        logic stall;
        logic [5:0] last_cmd;
        logic [7:0] crc_fail;
        logic aw_have;
        logic w_have;
        logic [4:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } core_s;
endpackage

// >>> test_memcard_command_and_erase_tagging.sv
// Purpose: self-checking bench for the card command core
// Assumes: timing registers written small
// Notes: expected results queue up until they appear
`timescale 1ns/10ps
module test_memcard_command_and_erase_tagging
    import memcard_pkg::*;
;
    logic core_clk, sys_rst, card_clk, cmd_in, cmd_out, cmd_oe, seen;
    logic dat_out, dat_oe, host_oe, host_out, resp_stb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [47:0] resp_word;
    logic [67:0] bus_q[$];
    logic [95:0] rsp_q[$];
    logic [67:0] bn;
    logic [95:0] fn;
    logic [15:0] acc;
    int error_cnt, total_checks, cyc;
    integer seed;
    // wire level: pull-up when nobody drives
    assign cmd_in = cmd_oe ? cmd_out : (host_oe ? host_out : 1'b1);
    memcard_cmd_core u_dut (.core_clk, .sys_rst, .card_clk, .cmd_in,
        .cmd_out, .cmd_oe, .dat_out, .dat_oe, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
    memcard_host_model u_host (.cmd_wire(cmd_in), .card_clk, .host_oe,
        .host_out, .resp_stb, .resp_word);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    ////////////////////////////////////////
    task automatic check_word(input logic [33:0] m, e, g);
        total_checks++;
        if ((g & m) !== (e & m)) begin
            error_cnt++;
            $display("ERROR bus word exp %h got %h", e & m, g & m);
        end
    endtask
    task automatic check_frame(input logic [47:0] m, e, g);
        total_checks++;
        if ((g & m) !== (e & m)) begin
            error_cnt++;
            $display("ERROR reply frame exp %h got %h", e & m, g & m);
        end
    endtask
    always @(posedge resp_stb) begin
        fn = rsp_q.size() ? rsp_q.pop_front() : {{48{1'b1}}, {48{1'bx}}};
        check_frame(fn[95:48], fn[47:0], resp_word);
    end
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        bus_q.push_back({34'h3_0000_0000, r, 32'h0});
        @(posedge core_clk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'($random(seed));
        forever begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [33:0] e, m);
        bus_q.push_back({m, e});
        @(posedge core_clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'($random(seed));
        forever begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
        end
        rready <= 1'b0;
    endtask
    task automatic cmd(input logic [5:0] i, input logic [31:0] a,
                       input logic rsp, input logic [31:0] sv);
        if (rsp) rsp_q.push_back({2'b11, 6'h3f, 32'h0008_2100, 8'h01,
            2'b00, i, sv | 32'h0000_0100, 8'h01});
        u_host.send(i, a, 1'b0);
    endtask
    function automatic logic supp(input int i);
        return i inside {[1:3], 7, [9:13], [16:18], 20, [23:30], [32:38], 42};
    endfunction
    task automatic complete_run;
        error_cnt += bus_q.size() + rsp_q.size();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // oldest note taken as each result shows; a hung host gives up
    always @(posedge core_clk) begin
        if ((rvalid && rready) || (bvalid && bready)) begin
            bn = bus_q.size() ? bus_q.pop_front() : {{34{1'b1}}, {34{1'bx}}};
            check_word(bn[67:34], bn[33:0],
                rvalid ? {rresp, rdata} : {bresp, 32'h0});
        end
        if (dat_oe) seen <= 1'b1;
        cyc++;
        if (cyc == 95000) begin
            error_cnt++;
            complete_run;
        end
    end
    ////////////////////////////////////////
    initial begin
        {sys_rst, seen, wstrb} = 6'h3f;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 42'h0;
        seed = 32'h6ec3_7d69;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(5'h00, 34'h0_0000_0010, 34'h3_ffff_ffff);
        rd(5'h04, 34'h0_0000_0004, 34'h3_ffff_ffff);
        rd(5'h10, 34'h0_0209_00ff, 34'h3_070f_0fff);
        rd(5'h18, 34'h2_0000_0000, 34'h3_ffff_ffff);
        wr(5'h14, 32'h0000_0f0f, 2'h2);
        rd(5'h14, 34'h0, 34'h0_0000_0f0f);
        acc = 16'h0002 + 16'($random(seed) & 3);
        wr(5'h00, {16'h0, acc}, 2'h0);
        wr(5'h04, 32'h1, 2'h0);
        rd(5'h00, {18'h0, acc}, 34'h3_ffff_ffff);
        u_host.send(6'h0d, 32'h0, 1'b1);
        rd(5'h0c, 34'h0_0001_0000, 34'h0_00ff_0000);
        for (int i = 0; i < 64; i++) begin
            cmd(i[5:0], 32'h0, supp(i) && !(i inside {0, 4, 15}), 32'h0);
        end
        rd(5'h0c, 34'h0, 34'h0_0000_0006);
        cmd(6'h23, 32'h0000_4000, 1'b1, 32'h0);
        cmd(6'h24, 32'h0000_2000, 1'b1, 32'h0);
        rd(5'h14, 34'h0_0000_0006, 34'h0_0000_000f);
        cmd(6'h0d, 32'h0, 1'b1, 32'h0000_2000);
        rd(5'h14, 34'h0, 34'h0_0000_000f);
        rd(5'h0c, 34'h0_0000_0010, 34'h0_0000_0018);
        cmd(6'h20, $random(seed), 1'b1, 32'h0);
        cmd(6'h23, 32'h0000_6000, 1'b1, 32'h0);
        seen = 1'b0;
        cmd(6'h26, 32'h0, 1'b1, 32'h0);
        check_word(34'h1, 34'h1, {33'h0, seen});
        rd(5'h0c, 34'h0, 34'h0_0000_000f);
        cmd(6'h1c, 32'h0000_6000, 1'b1, 32'h0);
        rd(5'h14, 34'h0_0000_0800, 34'h0_0000_0f00);
        cmd(6'h1d, 32'h0000_6000, 1'b1, 32'h0);
        rd(5'h14, 34'h0, 34'h0_0000_0f00);
        wr(5'h08, 32'h1, 2'h0);
        cmd(6'h18, 32'h0, 1'b1, 32'h0);
        rd(5'h0c, 34'h0_0000_0004, 34'h0_0000_0004);
        cmd(6'h0d, 32'h0, 1'b1, 32'h0008_0000);
        complete_run;
    end
endmodule
bind memcard_cmd_core memcard_cmd_asserts u_chk (.core_clk, .sys_rst,
    .cmd_out, .cmd_oe, .dat_out, .dat_oe, .awvalid, .awready, .wvalid,
    .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata);
